/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module tb_top;
  import tcsic_pkg::*;
  logic        clk_sys, rstn, hsel, hwrite, hreadyout, hresp, irq, internal_trigger_input;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, timer_input_pin, channel_out;
  logic [2:0]  hsize, req;
  int          fail_count, checks_done, cycles;
  tcsic_timer #(.CW(16)) DUT (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .timer_input_pin, .internal_trigger_input,
    .channel_out, .irq);
  tcsic_pins PINS (.clk_sys, .rstn, .req, .timer_input_pin, .internal_trigger_input);
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(string n, logic [7:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(n, e, q)
  endtask
  // pins hold for n cycles after each move; a dozen lets each edge clear the resync chain
  task automatic pin(logic [2:0] v, int n);
    req <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    rc("ctrl", TCSIC_OFF_CTRL, TCSIC_RST_WORD);
    rc("cnt", TCSIC_OFF_CNT, TCSIC_RST_WORD);
    rc("reload", TCSIC_OFF_RELD, {16'h0, TCSIC_RELD_RST});
    wr(8'h40, 32'hffff_ffff);
    rc("unmapped", 8'h40, 32'h0);
  endtask
  task automatic t_soft();
    wr(TCSIC_OFF_CTRL, 32'h1);
    pin(3'h0, 20);
    wr(TCSIC_OFF_CTRL, 32'h12);
    rc("ctrl bits", TCSIC_OFF_CTRL, 32'h12);
    xfer(1'b0, TCSIC_OFF_CNT, 32'h0);
    `CHK("cnt runs", 1'b1, q > 32'h10 && q < 32'h20)
    rc("cnt held", TCSIC_OFF_CNT, q);
    wr(TCSIC_OFF_CNT, 32'h100);
    wr(TCSIC_OFF_CTRL, 32'h11);
    pin(3'h0, 8);
    wr(TCSIC_OFF_CTRL, 32'h0);
    rc("cnt down", TCSIC_OFF_CNT, 32'hf6);
    wr(TCSIC_OFF_EVGEN, 32'h1 << TCSIC_EG_UG);
    rc("ug", TCSIC_OFF_EVGEN, 32'h0);
    rc("cnt clr", TCSIC_OFF_CNT, 32'h0);
  endtask
  task automatic t_ext();
    wr(TCSIC_OFF_CHCFG, 32'h0001_0000);
    for (int k = 0; k < 2; k++) begin
      wr(TCSIC_OFF_SMODE, {25'h0, k ? 3'h0 : TCSIC_TS_TI2, 1'b0, TCSIC_SM_EXT1});
      wr(TCSIC_OFF_CNT, 32'h0);
      wr(TCSIC_OFF_STAT, 32'h0);
      wr(TCSIC_OFF_CTRL, 32'h1);
      repeat (5) begin
        pin(k ? 3'h4 : 3'h2, 12);
        pin(3'h0, 12);
      end
      wr(TCSIC_OFF_CTRL, 32'h0);
      rc("edges", TCSIC_OFF_CNT, 32'h5);
      xfer(1'b0, TCSIC_OFF_STAT, 32'h0);
      `CHK("trg flag", 1'b1, q[TCSIC_ST_TRGF])
    end
  endtask
  task automatic t_cap();
    wr(TCSIC_OFF_SMODE, 32'h0);
    wr(TCSIC_OFF_CNT, 32'h1234);
    wr(TCSIC_OFF_STAT, 32'h0);
    wr(TCSIC_OFF_CHCFG, 32'h601);
    pin(3'h1, 12);
    `CHK("irq", 1'b1, irq)
    rc("captured", TCSIC_OFF_CCV1, 32'h1234);
    rc("read clr", TCSIC_OFF_STAT, 32'h0);
    wr(TCSIC_OFF_CCV1, 32'h0);
    rc("read only", TCSIC_OFF_CCV1, 32'h1234);
    wr(TCSIC_OFF_CNT, 32'h55);
    repeat (2) begin
      pin(3'h0, 12);
      pin(3'h1, 12);
    end
    rc("second", TCSIC_OFF_CCV1, 32'h55);
    rc("overcap", TCSIC_OFF_STAT, 32'h1 << TCSIC_ST_C1OF);
    wr(TCSIC_OFF_STAT, 32'h0);
    rc("of clr", TCSIC_OFF_STAT, 32'h0);
    wr(TCSIC_OFF_CHCFG, 32'h701);
    pin(3'h0, 12);
    rc("falling", TCSIC_OFF_STAT, 32'h1 << TCSIC_ST_C1IF);
    rc("fall val", TCSIC_OFF_CCV1, 32'h55);
    pin(3'h1, 12);
    rc("rise off", TCSIC_OFF_STAT, 32'h0);
    wr(TCSIC_OFF_CHCFG, 32'h501);
    pin(3'h0, 12);
    rc("disabled", TCSIC_OFF_STAT, 32'h0);
  endtask
  task automatic t_filt();
    wr(TCSIC_OFF_CHCFG, 32'h60d);
    pin(3'h1, 5);
    pin(3'h0, 20);
    rc("glitch", TCSIC_OFF_STAT, 32'h0);
    pin(3'h1, 20);
    pin(3'h0, 20);
    pin(3'h1, 20);
    rc("each edge", TCSIC_OFF_STAT, 32'h202);
    pin(3'h0, 20);
    wr(TCSIC_OFF_STAT, 32'h0);
    wr(TCSIC_OFF_CHCFG, 32'h64d);
    pin(3'h1, 20);
    pin(3'h0, 20);
    rc("div skip", TCSIC_OFF_STAT, 32'h0);
    pin(3'h1, 20);
    rc("div hit", TCSIC_OFF_STAT, 32'h1 << TCSIC_ST_C1IF);
    pin(3'h0, 20);
    wr(TCSIC_OFF_STAT, 32'h0);
  endtask
  task automatic t_gen();
    wr(TCSIC_OFF_CNT, 32'h77);
    wr(TCSIC_OFF_CHCFG, 32'h0601_0000);
    wr(TCSIC_OFF_EVGEN, 32'h1 << TCSIC_EG_C2G);
    pin(3'h0, 4);
    rc("gen flag", TCSIC_OFF_STAT, 32'h1 << TCSIC_ST_C2IF);
    `CHK("gen irq", 1'b1, irq)
    rc("gen val", TCSIC_OFF_CCV2, 32'h77);
  endtask
  task automatic t_pwm();
    wr(TCSIC_OFF_CHCFG, 32'h0302_0201);
    wr(TCSIC_OFF_SMODE, {25'h0, TCSIC_TS_TI1, 1'b0, TCSIC_SM_RESET});
    wr(TCSIC_OFF_CTRL, 32'h1);
    repeat (2) begin
      pin(3'h1, 30);
      pin(3'h0, 50);
    end
    pin(3'h1, 10);
    wr(TCSIC_OFF_CTRL, 32'h0);
    xfer(1'b0, TCSIC_OFF_CCV1, 32'h0);
    `CHK("period", 1'b1, q >= 32'd78 && q <= 32'd82)
    xfer(1'b0, TCSIC_OFF_CCV2, 32'h0);
    `CHK("duty", 1'b1, q >= 32'd28 && q <= 32'd32)
  endtask
  // update events with and without the block bit, reference read off the pin
  task automatic t_cmp();
    wr(TCSIC_OFF_SMODE, 32'h0);
    wr(TCSIC_OFF_CHCFG, 32'h0200_0200);
    wr(TCSIC_OFF_CCV1, 32'h8000);
    wr(TCSIC_OFF_CCV2, 32'h0);
    wr(TCSIC_OFF_EVGEN, 32'h1);
    pin(3'h1, 4);
    `CHK("ref hi", 2'b01, channel_out)
    wr(TCSIC_OFF_CHCFG, 32'h0a00_0a00);
    pin(3'h1, 4);
    `CHK("out pol", 2'b10, channel_out)
    wr(TCSIC_OFF_CHCFG, 32'h200);
    wr(TCSIC_OFF_CTRL, 32'h2);
    wr(TCSIC_OFF_CCV1, 32'h0);
    wr(TCSIC_OFF_EVGEN, 32'h1);
    pin(3'h1, 4);
    `CHK("blocked", 1'b1, channel_out[0])
    wr(TCSIC_OFF_CTRL, 32'h0);
    wr(TCSIC_OFF_EVGEN, 32'h1);
    pin(3'h1, 4);
    `CHK("ref lo", 1'b0, channel_out[0])
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    {rstn, hsel, hwrite, req} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    {fail_count, checks_done, cycles} = '0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_soft();
    t_ext();
    t_cap();
    t_filt();
    t_gen();
    t_pwm();
    t_cmp();
    summarize();
  end
endmodule
`default_nettype wire

/* tcsic_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module tcsic_checker
  import tcsic_pkg::*;
#(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins and outputs
  input wire logic [1:0]  timer_input_pin,
  input wire logic        internal_trigger_input,
  input wire logic [1:0]  channel_out,
  input wire logic        irq
);
  logic [1:0] pin_q;
  logic [7:0] since_pin;
  logic [7:0] since_bus;
  wire        tk = hsel & hready & htrans[1];
  wire        rd = tk & ~hwrite;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // idle time since the last pin change and bus transfer, saturating
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_q     <= 2'h0;
      since_pin <= 8'hff;
      since_bus <= 8'hff;
    end else begin
      pin_q     <= timer_input_pin;
      since_pin <= (timer_input_pin != pin_q) ? 8'h0 : since_pin + {7'h0, since_pin != 8'hff};
      since_bus <= tk ? 8'h0 : since_bus + {7'h0, since_bus != 8'hff};
    end
  end
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("slave stalled");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_hold; !rd |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; rd && haddr >= 32'h24 && haddr < 32'h100 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_stat; rd && haddr[7:0] == TCSIC_OFF_STAT |=> (hrdata & ~32'h647) == 32'h0; endproperty
  a_stat: assert property (p_stat) else $error("status spare bits set");
  property p_isrc; $rose(irq) |-> since_pin <= 8'd30 || since_bus <= 8'd30; endproperty
  a_isrc: assert property (p_isrc) else $error("irq without cause");
  property p_isync; $rose(irq) && since_bus > 8'd6 |-> since_pin >= 8'd2; endproperty
  a_isync: assert property (p_isync) else $error("pin not resynchronised");
  property p_iclr; $fell(irq) |-> since_bus <= 8'd4; endproperty
  a_iclr: assert property (p_iclr) else $error("flag cleared by itself");
  c_irq: cover property ($rose(irq));
  c_ovc: cover property (rd && haddr[7:0] == TCSIC_OFF_STAT ##1 hrdata[TCSIC_ST_C1OF]);
  c_out: cover property ($rose(channel_out[0]));
endmodule
bind tcsic_timer tcsic_checker #(.CW(CW)) u_chk (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_input_pin, .internal_trigger_input,
  .channel_out, .irq);
`default_nettype wire

/* tcsic_pins.sv */
`timescale 1ns/100ps
`default_nettype none
module tcsic_pins (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // levels asked by the bench: [1:0] pins, [2] trigger
  input  wire logic [2:0] req,
  // toward the timer
  output logic      [1:0] timer_input_pin,
  output logic            internal_trigger_input
);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_input_pin        <= 2'h0;
      internal_trigger_input <= 1'b0;
    end else begin
      timer_input_pin        <= req[1:0];
      internal_trigger_input <= req[2];
    end
  end
endmodule
`default_nettype wire

/* tcsic_pkg.sv */
package tcsic_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TCSIC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] TCSIC_OFF_SMODE = 8'h04;
  localparam logic [7:0] TCSIC_OFF_CHCFG = 8'h08;
  localparam logic [7:0] TCSIC_OFF_STAT  = 8'h0c;
  localparam logic [7:0] TCSIC_OFF_EVGEN = 8'h10;
  localparam logic [7:0] TCSIC_OFF_CNT   = 8'h14;
  localparam logic [7:0] TCSIC_OFF_RELD  = 8'h18;
  localparam logic [7:0] TCSIC_OFF_CCV1  = 8'h1c;
  localparam logic [7:0] TCSIC_OFF_CCV2  = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TCSIC_CTRL_CEN  = 0;
  localparam int TCSIC_CTRL_UDIS = 1;
  localparam int TCSIC_CTRL_DIR  = 4;
  localparam int TCSIC_ST_UIF    = 0;
  localparam int TCSIC_ST_C1IF   = 1;
  localparam int TCSIC_ST_C2IF   = 2;
  localparam int TCSIC_ST_TRGF   = 6;
  localparam int TCSIC_ST_C1OF   = 9;
  localparam int TCSIC_ST_C2OF   = 10;
  localparam int TCSIC_EG_UG     = 0;
  localparam int TCSIC_EG_C1G    = 1;
  localparam int TCSIC_EG_C2G    = 2;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TCSIC_SM_OFF   = 3'h0;
  localparam logic [2:0] TCSIC_SM_RESET = 3'h4;
  localparam logic [2:0] TCSIC_SM_EXT1  = 3'h7;
  localparam logic [2:0] TCSIC_TS_TI1   = 3'h5;
  localparam logic [2:0] TCSIC_TS_TI2   = 3'h6;
  localparam logic [1:0] TCSIC_SEL_OUT  = 2'h0;
  localparam logic [1:0] TCSIC_SEL_OWN  = 2'h1;
  localparam logic [1:0] TCSIC_SEL_CROSS = 2'h2;
  localparam logic [3:0] TCSIC_FLT_NONE = 4'h0;
  localparam logic [3:0] TCSIC_FLT_8    = 4'h3;
  localparam logic [1:0] TCSIC_DIV_NONE = 2'h0;
  localparam logic [15:0] TCSIC_RELD_RST = 16'hffff;
  localparam logic [31:0] TCSIC_RST_WORD = 32'h0000_0000;

  // per-channel configuration: [1:0] sel, [5:2] filter, [7:6] divider,
  // [8] polarity, [9] enable, [10] irq enable, [11] output polarity
  typedef struct packed {
    logic       opol;
    logic       ie;
    logic       en;
    logic       pol;
    logic [1:0] div;
    logic [3:0] flt;
    logic [1:0] sel;
  } tcsic_ch_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
  } tcsic_rsp_t;

endpackage

/* tcsic_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: count from internal, ext-mode-1 or internal trigger
// R2: slave off: software enable, direction, self-clearing update
// R3: slave mode 111 counts selected active edges
// R4: trigger select 110 routes channel 2 edge
// R5: ext clock edge counts once, sets trigger flag
// R6: filter 0000 none; divider off trigger path
// R7: sample, filter, polarity edge detect, then divider
// R8: reference wave active high, polarity at end
// R9: software reaches only preload register
// R10: capture into shadow, then copy to preload
// R11: compare copies preload to shadow, compares counter
// R12: capture stores counter, sets flag, irq if enabled
// R13: capture while flag set sets overcapture
// R14: flag clears on write 0 or value read
// R15: input channel makes value register read-only
// R16: filter 0011 needs 8 equal samples
// R17: polarity 0 rising, 1 falling
// R18: divider 00 captures every valid edge
// R19: capture only while channel enabled; software generate still captures on a disabled channel
// R20: software generate acts like real capture
// R21: select 01 own pin, 10 crossed pin
// R22: trigger 101 with slave 100 resets counter
// R23: update disable blocks preload transfers
// R24: software reads value before overcapture flag
module tcsic_timer
  import tcsic_pkg::*;
#(
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins and trigger
  input  wire logic [1:0]  timer_input_pin,
  input  wire logic        internal_trigger_input,
  // outputs
  output logic [1:0]       channel_out,
  output logic             irq
);
  import tcsic_pkg::*;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        wr_ph_r, rd_ph_r;
  logic [7:0]  addr_r;
  logic        ctrl_cen_r, ctrl_udis_r, ctrl_dir_r;
  logic [2:0]  slave_mode_select_r, trigger_source_select_r;
  tcsic_ch_t   ch_r [2];
  logic [CW-1:0] cnt_r, reld_r, reld_sh_r;
  logic [CW-1:0] pre_r [2];
  logic [CW-1:0] sh_r [2];
  logic        uif_r, trgf_r;
  logic [1:0]  cif_r, cof_r;
  logic        ug_r;
  logic [1:0]  cg_r;
  logic [31:0] rd_nxt;

  wire take = hsel & hready & htrans[1];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      addr_r  <= 8'h00;
    end else begin
      wr_ph_r <= take & hwrite;
      rd_ph_r <= take & ~hwrite;
      if (take)
        addr_r <= haddr[7:0];
    end
  end

  always_comb begin
    rd_nxt = TCSIC_RST_WORD;
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        TCSIC_OFF_CTRL:  rd_nxt = {27'h0, ctrl_dir_r, 2'h0, ctrl_udis_r, ctrl_cen_r};
        TCSIC_OFF_SMODE: rd_nxt = {25'h0, trigger_source_select_r, 1'b0, slave_mode_select_r};
        TCSIC_OFF_CHCFG: rd_nxt = {4'h0, ch_r[1], 4'h0, ch_r[0]};
        // status bits sit at the package's flag positions
        TCSIC_OFF_STAT:  rd_nxt = {21'h0, cof_r, 2'h0, trgf_r, 3'h0, cif_r, uif_r};
        TCSIC_OFF_CNT:   rd_nxt = 32'(cnt_r);
        TCSIC_OFF_RELD:  rd_nxt = 32'(reld_r);
        TCSIC_OFF_CCV1:  rd_nxt = 32'(pre_r[0]); // R9
        TCSIC_OFF_CCV2:  rd_nxt = 32'(pre_r[1]); // R9
        default:         rd_nxt = TCSIC_RST_WORD;
      endcase
    end
  end

  // read data registered at address phase: one wait-free data phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= TCSIC_RST_WORD;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      // a write leaves the last read data standing on the bus
      if (take && !hwrite)
        hrdata <= rd_nxt;
    end
  end

  wire wr_ctrl  = wr_ph_r && addr_r == TCSIC_OFF_CTRL;
  wire wr_smode = wr_ph_r && addr_r == TCSIC_OFF_SMODE;
  wire wr_chcfg = wr_ph_r && addr_r == TCSIC_OFF_CHCFG;
  wire wr_stat  = wr_ph_r && addr_r == TCSIC_OFF_STAT;
  wire wr_evgen = wr_ph_r && addr_r == TCSIC_OFF_EVGEN;
  wire wr_cnt   = wr_ph_r && addr_r == TCSIC_OFF_CNT;
  wire wr_reld  = wr_ph_r && addr_r == TCSIC_OFF_RELD;
  // reading the value at the address phase counts as reading the capture
  wire [1:0] rd_ccv = {take && !hwrite && haddr[7:0] == TCSIC_OFF_CCV2,
                       take && !hwrite && haddr[7:0] == TCSIC_OFF_CCV1};
  wire [1:0] wr_ccv = {wr_ph_r && addr_r == TCSIC_OFF_CCV2,
                       wr_ph_r && addr_r == TCSIC_OFF_CCV1};

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_cen_r              <= 1'b0;
      ctrl_udis_r             <= 1'b0;
      ctrl_dir_r              <= 1'b0;
      slave_mode_select_r     <= TCSIC_SM_OFF;
      trigger_source_select_r <= 3'h0;
      ch_r[0]                 <= '0;
      ch_r[1]                 <= '0;
      reld_r                  <= TCSIC_RELD_RST[CW-1:0];
    end else begin
      if (wr_ctrl) begin
        ctrl_cen_r  <= hwdata[TCSIC_CTRL_CEN]; // R2
        ctrl_udis_r <= hwdata[TCSIC_CTRL_UDIS];
        ctrl_dir_r  <= hwdata[TCSIC_CTRL_DIR];
      end
      if (wr_smode) begin
        slave_mode_select_r     <= hwdata[2:0];
        trigger_source_select_r <= hwdata[6:4];
      end
      if (wr_chcfg) begin
        ch_r[0] <= hwdata[11:0];
        ch_r[1] <= hwdata[27:16];
      end
      if (wr_reld)
        reld_r <= hwdata[CW-1:0];
    end
  end

  // generate bits clear themselves on the same edge that acts on them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ug_r <= 1'b0;
      cg_r <= 2'b00;
    end else begin
      ug_r <= wr_evgen & hwdata[TCSIC_EG_UG]; // R2
      cg_r <= wr_evgen ? {hwdata[TCSIC_EG_C2G], hwdata[TCSIC_EG_C1G]} : 2'b00;
    end
  end

  // ----------------------------------------------------------------
  // input stages
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [1:0] filt_r;
  logic [3:0] fcnt_r [2];
  logic [1:0] filt_d_r;
  logic [1:0] edge_fp;
  logic [1:0] cap_ev;
  logic [2:0] dcnt_r [2];

  // input 2 of the sync is the internal trigger from another timer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
    end else begin
      pin_s1_r <= {internal_trigger_input, timer_input_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // a pin change counts once the second and third stages agree

  // filter: setting 0011 needs 8 equal samples, other nonzero codes
  // are kept at the same length to keep the filter small
  for (genvar i = 0; i < 2; i++) begin : g_flt
    wire [3:0] need = (ch_r[i].flt == TCSIC_FLT_NONE) ? 4'h1 : 4'h8;
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        fcnt_r[i] <= 4'h0;
        filt_r[i] <= 1'b0;
      end else if (pin_s2_r[i] != pin_s3_r[i] || pin_s3_r[i] == filt_r[i]) begin
        fcnt_r[i] <= 4'h0;
      end else if (fcnt_r[i] + 4'h1 >= need) begin // R6 R16
        fcnt_r[i] <= 4'h0;
        filt_r[i] <= pin_s3_r[i]; // R7
      end else begin
        fcnt_r[i] <= fcnt_r[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      filt_d_r <= 2'b00;
    else
      filt_d_r <= filt_r;
  end

  // edge of each filtered input, chosen polarity
  wire [1:0] rise = filt_r & ~filt_d_r;
  wire [1:0] fall = ~filt_r & filt_d_r;

  always_comb begin
    logic src_r, src_f;
    src_r   = 1'b0;
    src_f   = 1'b0;
    edge_fp = 2'b00;
    for (int i = 0; i < 2; i++) begin
      src_r = (ch_r[i].sel == TCSIC_SEL_CROSS) ? rise[1-i] : rise[i]; // R21
      src_f = (ch_r[i].sel == TCSIC_SEL_CROSS) ? fall[1-i] : fall[i];
      edge_fp[i] = ch_r[i].pol ? src_f : src_r; // R17
    end
  end

  // trigger edge for the slave controller: channel 1, channel 2 or the internal trigger
  logic trg_d_r;
  logic trgi;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      trg_d_r <= 1'b0;
    else
      trg_d_r <= pin_s3_r[2];
  end

  always_comb begin
    unique case (trigger_source_select_r)
      TCSIC_TS_TI1: trgi = edge_fp[0];  // R22
      TCSIC_TS_TI2: trgi = edge_fp[1];  // R4
      default:      trgi = pin_s3_r[2] & ~trg_d_r; // R1
    endcase
  end

  // capture divider: trigger path bypasses it
  for (genvar i = 0; i < 2; i++) begin : g_div
    wire in_mode = ch_r[i].sel != TCSIC_SEL_OUT; // R15
    wire hit     = in_mode & ch_r[i].en & edge_fp[i]; // R19
    // three bits so that code 11 can wait out eight edges
    wire [2:0] wrap = (3'h1 << ch_r[i].div) - 3'h1;
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
        dcnt_r[i] <= 3'h0;
      else if (!in_mode || !ch_r[i].en)
        dcnt_r[i] <= 3'h0;
      else if (hit)
        dcnt_r[i] <= (dcnt_r[i] >= wrap) ? 3'h0 : dcnt_r[i] + 3'h1;
    end
    // R6 R18
    assign cap_ev[i] = hit && (ch_r[i].div == TCSIC_DIV_NONE || dcnt_r[i] >= wrap);
  end

  // ----------------------------------------------------------------
  // counter and slave controller
  // ----------------------------------------------------------------
  wire ext_mode = slave_mode_select_r == TCSIC_SM_EXT1;
  wire rst_mode = slave_mode_select_r == TCSIC_SM_RESET;
  // R1 R2 R3 R5
  wire tick     = ctrl_cen_r & (ext_mode ? trgi : 1'b1);
  wire ovf      = tick & (ctrl_dir_r ? cnt_r == '0 : cnt_r == reld_sh_r);
  wire upd      = (ovf | ug_r | (rst_mode & trgi)) & ~ctrl_udis_r; // R23

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r     <= '0;
      reld_sh_r <= TCSIC_RELD_RST[CW-1:0];
    end else begin
      if (wr_cnt)
        cnt_r <= hwdata[CW-1:0];
      else if (ug_r || (rst_mode && trgi)) // R22
        cnt_r <= '0;
      else if (tick)
        cnt_r <= ovf ? (ctrl_dir_r ? reld_sh_r : '0)
                     : (ctrl_dir_r ? cnt_r - CW'(1) : cnt_r + CW'(1));
      if (upd)
        reld_sh_r <= reld_r; // R23
    end
  end

  // ----------------------------------------------------------------
  // capture/compare values and status
  // ----------------------------------------------------------------
  wire [1:0] cap = cap_ev | cg_r; // R20
  logic [1:0] cap_d_r;

  for (genvar i = 0; i < 2; i++) begin : g_ccv
    wire in_mode = ch_r[i].sel != TCSIC_SEL_OUT;
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        sh_r[i]  <= '0;
        pre_r[i] <= '0;
      end else begin
        if (in_mode) begin
          if (cap[i])
            sh_r[i] <= cnt_r; // R10 R12
          if (cap_d_r[i])
            pre_r[i] <= sh_r[i]; // R10
        end else begin
          if (wr_ccv[i])
            pre_r[i] <= hwdata[CW-1:0]; // R9 R15
          if (upd)
            sh_r[i] <= pre_r[i]; // R11 R23
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cap_d_r <= 2'b00;
      uif_r   <= 1'b0;
      trgf_r  <= 1'b0;
      cif_r   <= 2'b00;
      cof_r   <= 2'b00;
    end else begin
      cap_d_r <= cap;
      // set wins over a clear in the same cycle
      uif_r  <= (uif_r & ~(wr_stat & ~hwdata[TCSIC_ST_UIF])) | upd;
      trgf_r <= (trgf_r & ~(wr_stat & ~hwdata[TCSIC_ST_TRGF])) | (trgi & (ext_mode | rst_mode)); // R5
      for (int i = 0; i < 2; i++) begin
        cif_r[i] <= (cif_r[i] & ~(wr_stat & ~hwdata[TCSIC_ST_C1IF + i]) & ~rd_ccv[i])
                    | cap[i]; // R12 R14
        cof_r[i] <= (cof_r[i] & ~(wr_stat & ~hwdata[TCSIC_ST_C1OF + i]))
                    | (cap[i] & cif_r[i]); // R13 R14
      end
    end
  end

  // ----------------------------------------------------------------
  // output stage and request
  // ----------------------------------------------------------------
  // reference is active high; pin polarity applied last
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      channel_out <= 2'b00;
      irq         <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++)
        channel_out[i] <= ch_r[i].en & ((cnt_r < sh_r[i]) ^ ch_r[i].opol); // R8 R11
      irq <= |(cif_r & {ch_r[1].ie, ch_r[0].ie}); // R12
    end
  end

endmodule
`default_nettype wire
